/* File: design/tcc_channel.sv */
// capture / width / delay timer channel, top level
// assumes single clk at 50 MHz, register master per plain strobe port
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module tcc_channel
	import tcc_pkg::*;
#(
	parameter int PRE_W = tcc_pkg::PRE_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic unit_clock_gate,
	input wire logic timer_pin,
	input wire logic serial_receive_input,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic channel_interrupt,
	output logic channel_enable_status,
	output logic upper_half_enable_one,
	output logic upper_half_enable_three,
	output logic output_bit
);
	import tcc_pkg::*;

	tcc_pins_if ev();
	chan_state_t state_q;
	logic [15:0] channel_mode_reg;
	logic [15:0] channel_data_capture;
	logic [15:0] channel_counter;
	logic counter_overflow_flag;
	logic wrap_q;
	logic lin_input_switch;
	logic [15:0] rdata_q;
	logic irq_q;
	logic start_w;
	logic stop_w;
	logic channel_start_trigger;
	logic channel_stop_trigger;
	logic [1:0] op;
	logic [1:0] edge_sel;
	logic start_edge;
	logic cap_edge;
	logic pin_edge;
	logic gate_q;

	assign op = channel_mode_reg[MODE_OP_LSB +: 2];
	assign edge_sel = {channel_mode_reg[MODE_EDGE_HI],
		channel_mode_reg[MODE_EDGE_LO]};

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	tcc_sampler #(.PRE_W(PRE_W)) u_samp (
		.clk(clk),
		.resetn(resetn),
		.gate(gate_q),
		.timer_pin(timer_pin),
		.serial_receive_input(serial_receive_input),
		.lin_input_switch(lin_input_switch),
		.count_clock_select(channel_mode_reg[MODE_CKS_LSB +: PRE_W]),
		.ev(ev)
	);

	// gate comes from the clock controller, so it passes two flops
	logic gate_m_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gate_m_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			gate_m_q <= unit_clock_gate;
			gate_q <= gate_m_q;
		end
	end

	// trigger bits are pulses from a write, never stored: self clearing
	assign channel_start_trigger = gate_q && wr && addr == OFF_TRIG
		&& wdata[TRIG_START];
	assign channel_stop_trigger = gate_q && wr && addr == OFF_TRIG
		&& wdata[TRIG_STOP];
	assign start_w = channel_start_trigger;
	assign stop_w = channel_stop_trigger;

	// pin edge selection; width mode picks edges from the edge field
	always_comb begin
		pin_edge = 1'b0;
		start_edge = 1'b0;
		cap_edge = 1'b0;
		case (edge_sel)
			2'h0: pin_edge = ev.fall;
			2'h1: pin_edge = ev.rise;
			default: pin_edge = ev.rise || ev.fall;
		endcase
		if (edge_sel == EDGE_HIGH) begin
			start_edge = ev.rise;
			cap_edge = ev.fall;
		end else if (edge_sel == EDGE_LOW) begin
			start_edge = ev.fall;
			cap_edge = ev.rise;
		end
		// pin edge only acts as trigger when source select says pin
		if (channel_mode_reg[MODE_TSS_LSB +: 3] != TSS_PIN) begin
			pin_edge = 1'b0;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// mode register: locked while running except edge bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_mode_reg <= MODE_RST;
		end else if (!gate_q) begin
			channel_mode_reg <= MODE_RST;
		end else if (wr && addr == OFF_MODE) begin
			if (channel_enable_status) begin
				channel_mode_reg[MODE_EDGE_HI] <= wdata[MODE_EDGE_HI];
				channel_mode_reg[MODE_EDGE_LO] <= wdata[MODE_EDGE_LO];
			end else begin
				channel_mode_reg <= wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lin_input_switch <= 1'b0;
		end else if (!gate_q) begin
			lin_input_switch <= 1'b0;
		end else if (wr && addr == OFF_CTRL) begin
			lin_input_switch <= wdata[CTRL_LIN];
		end
	end

	// ----------------------------------------
	// channel sequencer
	// ----------------------------------------
	logic do_cap;
	// pin edges already carry the tick; a software start must not wait
	assign do_cap = state_q == ST_RUN && op == OP_INTERVAL
		&& (pin_edge || start_w);
	logic w_cap;
	assign w_cap = state_q == ST_RUN && op == OP_WIDTH && cap_edge;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else if (!gate_q || stop_w) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_w) begin
						state_q <= (op == OP_INTERVAL) ? ST_RUN : ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (op == OP_WIDTH && start_edge) begin
						state_q <= ST_RUN;
					end else if (op == OP_DELAY && (pin_edge || start_w)) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (w_cap) begin
						state_q <= ST_WAIT;
					end else if (op == OP_DELAY && ev.tick
						&& channel_counter == CNT_ZERO) begin
						state_q <= ST_WAIT;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign channel_enable_status = state_q != ST_IDLE;
	// delay mode also reports the upper-half enables
	assign upper_half_enable_one = channel_enable_status
		&& op == OP_DELAY;
	assign upper_half_enable_three = upper_half_enable_one;
	assign output_bit = 1'b0;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_counter <= CNT_ZERO;
		end else if (!gate_q) begin
			channel_counter <= CNT_ZERO;
		end else if (stop_w) begin
			channel_counter <= channel_counter;
		end else if (state_q == ST_IDLE && start_w && op == OP_INTERVAL) begin
			channel_counter <= CNT_ZERO;
		end else if (do_cap) begin
			channel_counter <= CNT_ZERO;
		end else if (state_q == ST_WAIT && op == OP_WIDTH && start_edge) begin
			channel_counter <= CNT_ZERO;
		end else if (w_cap) begin
			channel_counter <= channel_counter + 16'h0001;
		end else if (op == OP_DELAY && (state_q == ST_WAIT
			|| state_q == ST_RUN) && (pin_edge || start_w)) begin
			// reload reads the data register now, so rewrites act next cycle
			channel_counter <= channel_data_capture;
		end else if (state_q == ST_RUN && ev.tick) begin
			if (op == OP_DELAY) begin
				if (channel_counter != CNT_ZERO) begin
					channel_counter <= channel_counter - 16'h0001;
				end
			end else begin
				channel_counter <= channel_counter + 16'h0001;
			end
		end
	end

	// wrap memory: one sticky bit, so two wraps look like one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrap_q <= 1'b0;
		end else if (!gate_q || do_cap || w_cap) begin
			wrap_q <= 1'b0;
		end else if (state_q == ST_IDLE && start_w) begin
			wrap_q <= 1'b0;
		end else if (state_q == ST_WAIT && start_edge) begin
			wrap_q <= 1'b0;
		end else if (state_q == ST_RUN && ev.tick && op != OP_DELAY
			&& channel_counter == CNT_MAX) begin
			wrap_q <= 1'b1;
		end
	end

	// capture flag tracks the wrap of this measurement only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			counter_overflow_flag <= 1'b0;
		end else if (!gate_q) begin
			counter_overflow_flag <= 1'b0;
		end else if (do_cap || w_cap) begin
			counter_overflow_flag <= wrap_q;
		end
	end

	// data register: software write or capture; capture wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_data_capture <= DATA_RST;
		end else if (!gate_q) begin
			channel_data_capture <= DATA_RST;
		end else if (do_cap || w_cap) begin
			channel_data_capture <= channel_counter;
		end else if (wr && addr == OFF_DATA) begin
			channel_data_capture <= wdata;
		end
	end

	// ----------------------------------------
	// interrupt pulse
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= gate_q && ((state_q == ST_IDLE && start_w
				&& op == OP_INTERVAL && channel_mode_reg[MODE_SIS])
				|| do_cap || w_cap
				|| (op == OP_DELAY && state_q == ST_RUN && ev.tick
				&& channel_counter == CNT_ZERO));
		end
	end
	assign channel_interrupt = irq_q;

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
		end else if (!rd) begin
			rdata_q <= 16'h0000;
		end else if (addr == OFF_MODE) begin
			rdata_q <= channel_mode_reg;
		end else if (addr == OFF_DATA) begin
			rdata_q <= channel_data_capture;
		end else if (addr == OFF_COUNT) begin
			rdata_q <= channel_counter;
		end else if (addr == OFF_STATUS) begin
			rdata_q <= {14'h0000, channel_enable_status,
				counter_overflow_flag};
		end else if (addr == OFF_CTRL) begin
			rdata_q <= {14'h0000, lin_input_switch, 1'b0};
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign rdata = rdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	stop_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		stop_w |=> !channel_enable_status)
		else $error("stop did not clear enable");
	stop_ovf_a: assert property (@(posedge clk) disable iff (!resetn)
		stop_w && !do_cap && !w_cap |=> $stable(counter_overflow_flag))
		else $error("stop changed overflow flag");
	cap_data_a: assert property (@(posedge clk) disable iff (!resetn)
		do_cap && !stop_w |=> channel_data_capture == $past(channel_counter)
		&& channel_counter == CNT_ZERO && channel_interrupt)
		else $error("interval capture wrong");
	width_plus_a: assert property (@(posedge clk) disable iff (!resetn)
		w_cap && !stop_w |=> channel_counter ==
		channel_data_capture + 16'h0001)
		else $error("width hold value wrong");
	ovf_upd_a: assert property (@(posedge clk) disable iff (!resetn)
		(do_cap || w_cap) && gate_q |=> counter_overflow_flag ==
		$past(wrap_q))
		else $error("overflow flag not updated");
	delay_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		op == OP_DELAY && state_q == ST_RUN && ev.tick && gate_q
		&& channel_counter == CNT_ZERO |=> channel_interrupt)
		else $error("delay zero without interrupt");
	gate_init_a: assert property (@(posedge clk) disable iff (!resetn)
		!gate_q |=> channel_counter == CNT_ZERO
		&& !channel_enable_status)
		else $error("gate off did not initialise");
	start_int_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE && start_w && op == OP_INTERVAL && !stop_w
		|=> channel_enable_status && channel_counter == CNT_ZERO)
		else $error("interval start wrong");
	cap_cov: cover property (@(posedge clk) do_cap);
	width_cov: cover property (@(posedge clk) w_cap);
	delay_cov: cover property (@(posedge clk) op == OP_DELAY
		&& channel_interrupt);
endmodule

/* File: design/tcc_pkg.sv */
// package for the capture/delay timer channel
// assumes a single 50 MHz clock domain; imported by the channel top level and the bench only
package tcc_pkg;
	// ----------------------------------------
	// register offsets (plain port, byte address)
	// ----------------------------------------
	localparam logic [3:0] OFF_MODE = 4'h0;
	localparam logic [3:0] OFF_DATA = 4'h4;
	localparam logic [3:0] OFF_COUNT = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;
	localparam logic [3:0] OFF_TRIG = 4'h1;
	localparam logic [3:0] OFF_CTRL = 4'h2;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MODE_SIS = 0;
	localparam int MODE_EDGE_LO = 1;
	localparam int MODE_EDGE_HI = 2;
	localparam int MODE_OP_LSB = 3;
	localparam int MODE_TSS_LSB = 5;
	localparam int MODE_CKS_LSB = 8;
	localparam int TRIG_START = 0;
	localparam int TRIG_STOP = 1;
	localparam int STAT_OVF = 0;
	localparam int STAT_EN = 1;
	localparam int CTRL_LIN = 1;
	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] OP_INTERVAL = 2'h0;
	localparam logic [1:0] OP_WIDTH = 2'h1;
	localparam logic [1:0] OP_DELAY = 2'h2;
	localparam logic [2:0] TSS_PIN = 3'h1;
	localparam logic [1:0] EDGE_LOW = 2'h2;
	localparam logic [1:0] EDGE_HIGH = 2'h3;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam int PRE_W = 4;
	// state of the channel sequencer
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_HOLD = 4'b1000
	} chan_state_t;
endpackage

/* File: design/tcc_pins_if.sv */
// interface carrying the conditioned input events to the channel core
// assumes producer and consumer share clk
`timescale 1ns/10ps
interface tcc_pins_if;
	logic tick;
	logic rise;
	logic fall;
	logic level;
	modport src(output tick, output rise, output fall, output level);
	modport dst(input tick, input rise, input fall, input level);
endinterface

/* File: design/tcc_sampler.sv */
// input sampler: synchroniser, count clock divider, edge detection
// assumes pins are asynchronous to clk; edges seen only on count ticks
`timescale 1ns/10ps
module tcc_sampler #(
	parameter int PRE_W = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic gate,
	input wire logic timer_pin,
	input wire logic serial_receive_input,
	input wire logic lin_input_switch,
	input wire logic [PRE_W-1:0] count_clock_select,
	tcc_pins_if.src ev
);
	logic [1:0] sync_q;
	logic rx_meta_q;
	logic rx_q;
	logic [PRE_W-1:0] div_q;
	logic samp_q;
	logic sel;
	// ----------------------------------------
	// two-stage synchronisers for both inputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_q <= 2'h0;
			rx_meta_q <= 1'b0;
			rx_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[0], timer_pin};
			rx_meta_q <= serial_receive_input;
			rx_q <= rx_meta_q;
		end
	end
	// lin switch picks the serial receive line instead of the pin
	assign sel = lin_input_switch ? rx_q : sync_q[1];
	// divider: tick every count_clock_select+1 cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
		end else if (!gate || div_q >= count_clock_select) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end
	assign ev.tick = gate && (div_q >= count_clock_select);
	// sampled on the count clock, hence up to one tick of error
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			samp_q <= 1'b0;
		end else if (!gate) begin
			samp_q <= 1'b0;
		end else if (ev.tick) begin
			samp_q <= sel;
		end
	end
	assign ev.rise = ev.tick && sel && !samp_q;
	assign ev.fall = ev.tick && !sel && samp_q;
	assign ev.level = samp_q;
endmodule

/* File: test/tcc_pulse_source.sv */
// partner model: the signal source that feeds the measured input
// assumes the bench clock; a train starts on a one-cycle go strobe
`timescale 1ns/10ps
module tcc_pulse_source (
	input wire logic clk,
	input wire logic go,
	input wire logic to_serial,
	input wire logic [31:0] hi_len,
	input wire logic [31:0] lo_len,
	input wire logic [3:0] pulses,
	output logic pin,
	output logic serial,
	output logic busy
);
	// ----------------------------------------
	// pulse train generator
	// ----------------------------------------
	// pin idles low, the receive line idles high as a serial line does
	initial begin
		pin = 1'b0;
		serial = 1'b1;
		busy = 1'b0;
	end

	// active level: high on the pin, low on the receive line
	task automatic drive(input logic act);
		if (to_serial) begin
			serial <= ~act;
		end else begin
			pin <= act;
		end
	endtask

	// last pulse skips its trailing low, so a long period costs one span
	always @(posedge clk) begin
		if (go) begin
			busy <= 1'b1;
			for (int i = 0; i < int'(pulses); i++) begin
				drive(1'b1);
				repeat (hi_len) @(posedge clk);
				drive(1'b0);
				if (i < int'(pulses) - 1) repeat (lo_len) @(posedge clk);
			end
			@(posedge clk);
			busy <= 1'b0;
		end
	end
endmodule

/* File: test/tcc_channel_bench.sv */
// self-checking bench for the capture/delay timer channel
// assumes count divider 0, so every clock is a count tick
`timescale 1ns/10ps
module tcc_channel_bench;
	import tcc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic gate = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_q = 1'b0;
	logic [15:0] rdata, got, hold;
	logic [31:0] note;
	logic irq, en, up1, up3, obit, pin, ser, busy;
	logic go = 1'b0;
	logic sel = 1'b0;
	logic [31:0] hi = 32'h0;
	logic [31:0] lo = 32'h0;
	logic [3:0] np = 4'h0;
	logic [31:0] expq[$];
	int n_fail = 0;
	int tests_run = 0;
	int seed = 90;
	int n, t1, t2, t3, t4, h;

	always #10 clk = ~clk;

	tcc_channel dut (.clk(clk), .resetn(resetn), .unit_clock_gate(gate),
		.timer_pin(pin), .serial_receive_input(ser), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.channel_interrupt(irq), .channel_enable_status(en),
		.upper_half_enable_one(up1), .upper_half_enable_three(up3),
		.output_bit(obit));

	tcc_pulse_source src (.clk(clk), .go(go), .to_serial(sel),
		.hi_len(hi), .lo_len(lo), .pulses(np), .pin(pin), .serial(ser),
		.busy(busy));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q) begin
			got = rdata;
			note = expq.pop_front();
			if (note[31:16] != 16'h0000) begin
				chk(rdata & note[31:16], note[15:0] & note[31:16]);
			end
		end
	end

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// let the edge that took the write settle before any look
		#1;
	endtask

	// a zero mask only fetches the value into got
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e,
		input logic [15:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back({m, e});
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// bounded wait; k is the edge count until the pulse is seen
	task automatic wait_irq(input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(posedge clk);
			if (irq === 1'b1) break;
		end
		if (k > lim) chk(16'h0001, 16'h0000);
	endtask

	task automatic train(input logic s, input int hl, input int ll,
		input int k);
		while (busy === 1'b1) @(posedge clk);
		@(posedge clk);
		sel <= s;
		hi <= hl;
		lo <= ll;
		np <= k[3:0];
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// watchdog sized well past the one long overflow period
	initial begin
		#1800000;
		n_fail++;
		stop_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(OFF_MODE, MODE_RST, 16'hFFFF);
		rd_reg(OFF_DATA, DATA_RST, 16'hFFFF);
		rd_reg(OFF_STATUS, 16'h0000, 16'hFFFF);
		rd_reg(4'h3, 16'h0000, 16'hFFFF);
		// interval mode, pin rising edge, interrupt on start
		wr_reg(OFF_MODE, 16'h0023);
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(4, n);
		chk({15'h0, en}, 16'h0001);
		rd_reg(OFF_TRIG, 16'h0000, 16'hFFFF);
		wr_reg(OFF_MODE, 16'h0015);
		rd_reg(OFF_MODE, 16'h0025, 16'hFFFF);
		wr_reg(OFF_MODE, 16'h0023);
		train(1'b0, 20, 20, 4);
		for (int i = 0; i < 4; i++) begin
			wait_irq(200, n);
			rd_reg(OFF_DATA, 16'd39, (i == 0) ? 16'h0 : 16'hFFFF);
			rd_reg(OFF_STATUS, 16'h0002, 16'h0003);
		end
		// software start while running is a capture, so it interrupts
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(4, n);
		// one period past a full wrap
		train(1'b0, 20, 65616, 2);
		wait_irq(200, n);
		wait_irq(66000, n);
		rd_reg(OFF_DATA, 16'd99, 16'hFFFF);
		rd_reg(OFF_STATUS, 16'h0003, 16'h0003);
		wr_reg(OFF_TRIG, 16'h0002);
		chk({15'h0, en}, 16'h0000);
		rd_reg(OFF_STATUS, 16'h0001, 16'h0003);
		rd_reg(OFF_COUNT, 16'h0000, 16'h0000);
		hold = got;
		repeat (10) @(posedge clk);
		rd_reg(OFF_COUNT, hold, 16'hFFFF);
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(4, n);
		train(1'b0, 20, 20, 2);
		wait_irq(200, n);
		wait_irq(200, n);
		rd_reg(OFF_DATA, 16'd39, 16'hFFFF);
		rd_reg(OFF_STATUS, 16'h0002, 16'h0003);
		wr_reg(OFF_TRIG, 16'h0002);
		// width cases: pin high, pin low, receive line low
		for (int i = 0; i < 3; i++) begin
			h = 20 + ($random(seed) & 15);
			wr_reg(OFF_CTRL, (i == 2) ? 16'h0002 : 16'h0000);
			wr_reg(OFF_MODE, (i == 0) ? 16'h002E : 16'h002C);
			wr_reg(OFF_TRIG, 16'h0001);
			chk({15'h0, en}, 16'h0001);
			train(i == 2, (i == 1) ? 20 : h, h, (i == 1) ? 2 : 1);
			wait_irq(200, n);
			rd_reg(OFF_DATA, 16'(h - 1), 16'hFFFF);
			rd_reg(OFF_COUNT, 16'(h), 16'hFFFF);
			repeat (5) @(posedge clk);
			rd_reg(OFF_COUNT, 16'(h), 16'hFFFF);
			rd_reg(OFF_STATUS, 16'h0002, 16'h0003);
			// stop bit written to end the channel before the next width case
			wr_reg(OFF_TRIG, 16'h0002);
		end
		wr_reg(OFF_CTRL, 16'h0000);
		// delay counter: start waits, a second start loads and runs
		wr_reg(OFF_DATA, 16'd20);
		wr_reg(OFF_MODE, 16'h0032);
		wr_reg(OFF_TRIG, 16'h0001);
		chk({13'h0, en, up1, up3}, 16'h0007);
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(300, t1);
		rd_reg(OFF_COUNT, 16'h0000, 16'hFFFF);
		repeat (10) @(posedge clk);
		rd_reg(OFF_COUNT, 16'h0000, 16'hFFFF);
		wr_reg(OFF_DATA, 16'd50);
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(300, t2);
		chk(16'(t2 - t1), 16'd30);
		wr_reg(OFF_TRIG, 16'h0001);
		wr_reg(OFF_DATA, 16'd10);
		wait_irq(300, t3);
		chk(16'(t3 + 2), 16'(t2));
		wr_reg(OFF_TRIG, 16'h0001);
		wait_irq(300, t4);
		chk(16'(t4), 16'(t1 - 10));
		train(1'b0, 20, 20, 1);
		wait_irq(300, n);
		// trigger source other than the pin: a pin edge must not load
		wr_reg(OFF_TRIG, 16'h0002);
		wr_reg(OFF_DATA, 16'h0FFF);
		wr_reg(OFF_MODE, 16'h0012);
		wr_reg(OFF_TRIG, 16'h0001);
		train(1'b0, 20, 20, 1);
		repeat (30) @(posedge clk);
		rd_reg(OFF_COUNT, 16'h0000, 16'hFFFF);
		// clock gate removed mid-run
		@(posedge clk);
		gate <= 1'b0;
		repeat (6) @(posedge clk);
		gate <= 1'b1;
		repeat (4) @(posedge clk);
		chk({12'h0, en, up1, up3, obit}, 16'h0000);
		rd_reg(OFF_MODE, MODE_RST, 16'hFFFF);
		rd_reg(OFF_DATA, DATA_RST, 16'hFFFF);
		rd_reg(OFF_STATUS, 16'h0000, 16'hFFFF);
		stop_test();
	end
endmodule
